// >>> design/rtcc_regs.vh
// How it works
// - Top is 0xffffff normally, or the channel-zero match value in top mode.
// - Enable makes counter advance each prescaled tick unless a debug halt freezes it with DBGRUN clear; disable clears it.
// - Counter value register shows live 24-bit count, readable and writable.
// - Channel-zero match sets its flag and offers a start trigger to the timer.
// - Flag-set register: writing one sets that flag, zero leaves it.
// - Flag-clear register: writing one clears that flag, zero leaves it.
// - Counter wraps to zero past top; the wrap flag is raised only when top mode is off.
// - Interrupt is high while any flag and its enable are both set.
// - Each compare channel pulses its event output for one counter tick.
`ifndef RTCC_REGS_VH
`define RTCC_REGS_VH
`define RTCC_OFF_CTRL 8'h00
`define RTCC_OFF_CNT 8'h04
`define RTCC_OFF_CMP0 8'h08
`define RTCC_OFF_CMP1 8'h0c
`define RTCC_OFF_IF 8'h10
`define RTCC_OFF_IFS 8'h14
`define RTCC_OFF_IFC 8'h18
`define RTCC_OFF_IEN 8'h1c
`define RTCC_OFF_HOLD 8'h20
`define RTCC_OFF_PEND 8'h24
`define RTCC_CTRL_EN 0
`define RTCC_CTRL_DBGRUN 1
`define RTCC_CTRL_TOP 2
`define RTCC_IF_WRAP 0
`define RTCC_IF_CMP0 1
`define RTCC_IF_CMP1 2
`define RTCC_PEND_CTRL 0
`define RTCC_PEND_CMP0 1
`define RTCC_PEND_CMP1 2
`define RTCC_CNT_RESET 24'h000000
`define RTCC_CNT_MAX 24'hffffff
`define RTCC_TRANSFER_CYCLES 2'h3
`endif

// >>> design/rtcc_sync.v
`timescale 1ns/1ps
// Three-stage synchroniser; the output changes once stages two and three agree.
module rtcc_sync (
    input wire i_clk, // Core clock.
    input wire i_rst, // Synchronous reset.
    input wire i_async, // Level from outside the clock domain.
    output reg o_level // Filtered synchronised level.
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    always @(posedge i_clk) begin
        if (i_rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            o_level <= 1'b0;
        end else begin
            s1_reg <= i_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                o_level <= s3_reg;
            end
        end
    end
endmodule

// >>> design/rtcc_top.v
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "rtcc_regs.vh"
module rtcc_top #(
    parameter CNT_W = 24 // Counter width.
) (
    input wire I_CORE_CLK, // 40 MHz core clock.
    input wire I_RST, // Synchronous reset, active high.
    input wire [7:0] I_ADDR, // Register byte address.
    input wire [31:0] I_WDATA, // Write data.
    input wire I_WR, // Write strobe.
    input wire I_RD, // Read strobe.
    output reg [31:0] O_RDATA, // Read data, cycle after strobe.
    input wire I_TICK, // Prescaled counter tick from outside the domain.
    input wire I_DBG_HALT, // Processor halted by debugger.
    output wire O_IRQ, // Level interrupt request.
    output reg O_EVT_CMP0, // Channel-zero event pulse.
    output reg O_EVT_CMP1, // Channel-one event pulse.
    output reg O_TIMER_START // Start trigger to the waveform timer.
);
    reg [2:0] control_reg;
    reg [CNT_W-1:0] counter_value_reg;
    reg [CNT_W-1:0] match_value_zero_reg;
    reg [CNT_W-1:0] match_value_one_reg;
    reg [2:0] irq_flags_reg;
    reg [2:0] irq_enable_reg;
    reg update_hold_reg;
    reg [2:0] domain_transfer_pending_reg;
    reg [1:0] pend_cnt_reg;
    reg tick_q_reg;
    reg top_clear_reg;
    reg [CNT_W-1:0] counter_value_next;
    reg [2:0] flags_next;
    wire tick_lvl;
    wire halt_lvl;
    wire tick;
    wire run;
    wire [CNT_W-1:0] top;
    wire hit0;
    wire hit1;
    wire at_top;
    wire wr_ctrl;
    wire wr_cnt;
    wire [1:0] pend_idx;

    rtcc_sync u_tick (
        .i_clk(I_CORE_CLK),
        .i_rst(I_RST),
        .i_async(I_TICK),
        .o_level(tick_lvl)
    );
    rtcc_sync u_halt (
        .i_clk(I_CORE_CLK),
        .i_rst(I_RST),
        .i_async(I_DBG_HALT),
        .o_level(halt_lvl)
    );

    function hit;
        input [CNT_W-1:0] a;
        input [CNT_W-1:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    assign tick = tick_lvl & ~tick_q_reg;
    // Counting advances only when enabled and not frozen by a debug halt.
    assign run = control_reg[`RTCC_CTRL_EN] & tick
        & (~halt_lvl | control_reg[`RTCC_CTRL_DBGRUN]);
    assign top = control_reg[`RTCC_CTRL_TOP] ? match_value_zero_reg
        : `RTCC_CNT_MAX;
    assign hit0 = run & hit(counter_value_reg, match_value_zero_reg);
    assign hit1 = run & hit(counter_value_reg, match_value_one_reg);
    assign at_top = run & hit(counter_value_reg, top);
    assign wr_ctrl = I_WR & (I_ADDR == `RTCC_OFF_CTRL);
    assign wr_cnt = I_WR & (I_ADDR == `RTCC_OFF_CNT);
    // Maps control, match zero and match one offsets onto pending bits 0, 1 and 2.
    assign pend_idx = I_ADDR[3:2] - {1'b0, I_ADDR[3]};
    assign O_IRQ = |(irq_flags_reg & irq_enable_reg);

    always @* begin
        counter_value_next = counter_value_reg;
        if (!control_reg[`RTCC_CTRL_EN]) begin
            counter_value_next = `RTCC_CNT_RESET;
        end else if (run) begin
            if (top_clear_reg || at_top) begin
                counter_value_next = `RTCC_CNT_RESET;
            end else begin
                counter_value_next = counter_value_reg + 1'b1;
            end
        end
        if (wr_cnt) begin
            counter_value_next = I_WDATA[CNT_W-1:0];
        end
    end

    always @* begin
        flags_next = irq_flags_reg;
        if (I_WR && I_ADDR == `RTCC_OFF_IFC) begin
            flags_next = flags_next & ~I_WDATA[2:0];
        end
        if (I_WR && I_ADDR == `RTCC_OFF_IFS) begin
            flags_next = flags_next | I_WDATA[2:0];
        end
        // Hardware events are applied last so a same-cycle clear cannot lose them.
        if (at_top && !control_reg[`RTCC_CTRL_TOP]) begin
            flags_next[`RTCC_IF_WRAP] = 1'b1;
        end
        if (hit0) begin
            flags_next[`RTCC_IF_CMP0] = 1'b1;
        end
        if (hit1) begin
            flags_next[`RTCC_IF_CMP1] = 1'b1;
        end
    end

    always @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            control_reg <= 3'h0;
            counter_value_reg <= `RTCC_CNT_RESET;
            match_value_zero_reg <= `RTCC_CNT_RESET;
            match_value_one_reg <= `RTCC_CNT_RESET;
            irq_flags_reg <= 3'h0;
            irq_enable_reg <= 3'h0;
            update_hold_reg <= 1'b0;
            tick_q_reg <= 1'b0;
            top_clear_reg <= 1'b0;
            O_EVT_CMP0 <= 1'b0;
            O_EVT_CMP1 <= 1'b0;
            O_TIMER_START <= 1'b0;
        end else begin
            tick_q_reg <= tick_lvl;
            counter_value_reg <= counter_value_next;
            irq_flags_reg <= flags_next;
            if (run) begin
                top_clear_reg <= 1'b0;
                O_EVT_CMP0 <= hit0;
                O_EVT_CMP1 <= hit1;
                O_TIMER_START <= hit0;
            end
            if (wr_ctrl) begin
                control_reg <= I_WDATA[2:0];
            end
            if (I_WR && I_ADDR == `RTCC_OFF_CMP0) begin
                match_value_zero_reg <= I_WDATA[CNT_W-1:0];
            end
            if (I_WR && I_ADDR == `RTCC_OFF_CMP1) begin
                match_value_one_reg <= I_WDATA[CNT_W-1:0];
            end
            if (I_WR && I_ADDR == `RTCC_OFF_IEN) begin
                irq_enable_reg <= I_WDATA[2:0];
            end
            if (I_WR && I_ADDR == `RTCC_OFF_HOLD) begin
                update_hold_reg <= I_WDATA[0];
            end
        end
    end

    // Writes to async registers made with update hold off stay pending for a fixed transfer window, longer if hold is then set.
    always @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            domain_transfer_pending_reg <= 3'h0;
            pend_cnt_reg <= 2'h0;
        end else begin
            if (I_WR && !update_hold_reg && (I_ADDR == `RTCC_OFF_CTRL
                || I_ADDR == `RTCC_OFF_CMP0 || I_ADDR == `RTCC_OFF_CMP1)) begin
                domain_transfer_pending_reg[pend_idx] <= 1'b1;
                pend_cnt_reg <= `RTCC_TRANSFER_CYCLES;
            end else if (pend_cnt_reg != 2'h0) begin
                pend_cnt_reg <= pend_cnt_reg - 2'h1;
            end else if (!update_hold_reg) begin
                domain_transfer_pending_reg <= 3'h0;
            end
        end
    end

    always @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            O_RDATA <= 32'h00000000;
        end else if (I_RD) begin
            case (I_ADDR)
                `RTCC_OFF_CTRL: O_RDATA <= {29'h0, control_reg};
                `RTCC_OFF_CNT: O_RDATA <= {8'h00, counter_value_reg};
                `RTCC_OFF_CMP0: O_RDATA <= {8'h00, match_value_zero_reg};
                `RTCC_OFF_CMP1: O_RDATA <= {8'h00, match_value_one_reg};
                `RTCC_OFF_IF: O_RDATA <= {29'h0, irq_flags_reg};
                `RTCC_OFF_IEN: O_RDATA <= {29'h0, irq_enable_reg};
                `RTCC_OFF_HOLD: O_RDATA <= {31'h0, update_hold_reg};
                `RTCC_OFF_PEND: O_RDATA <= {29'h0, domain_transfer_pending_reg};
                default: O_RDATA <= 32'h00000000;
            endcase
        end else begin
            O_RDATA <= 32'h00000000;
        end
    end
endmodule

// >>> test/rtcc_top_assertions.sv
`timescale 1ns/1ps
module rtcc_top_assertions #(
    parameter CNT_W = 24
) (
    input wire logic I_CORE_CLK, // Clock.
    input wire logic I_RST, // Reset.
    input wire logic [7:0] I_ADDR, // Address.
    input wire logic [31:0] I_WDATA, // Write data.
    input wire logic I_WR, // Write.
    input wire logic I_RD, // Read.
    input wire logic [31:0] O_RDATA, // Read data.
    input wire logic I_TICK, // Tick.
    input wire logic O_IRQ, // Interrupt.
    input wire logic O_EVT_CMP0, // Event.
    input wire logic O_TIMER_START // Start.
);
    logic [2:0] ctrl_reg;
    logic [2:0] ien_reg;
    logic [4:0] age_reg;
    default clocking @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_RST);
    sequence s_rd(a);
        I_RD && I_ADDR == a;
    endsequence
    // Age counts cycles since the tick input rose, saturating.
    always @(posedge I_CORE_CLK) begin
        if (I_RST || (I_WR && I_ADDR == 8'h00))
            ctrl_reg <= I_RST ? 3'h0 : I_WDATA[2:0];
        if (I_RST || (I_WR && I_ADDR == 8'h1c))
            ien_reg <= I_RST ? 3'h0 : I_WDATA[2:0];
        if (I_RST)
            age_reg <= 5'h1f;
        else if ($rose(I_TICK))
            age_reg <= 5'h00;
        else if (age_reg != 5'h1f)
            age_reg <= age_reg + 5'h01;
    end
    a_read_idle_zero: assert property (!I_RD |=> O_RDATA == 32'h0)
        else $error("read data not zero when idle");
    a_ctrl_read_back: assert property (s_rd(8'h00) |=> O_RDATA == {29'h0, ctrl_reg})
        else $error("control read wrong");
    a_unmapped_read_zero: assert property (I_RD && I_ADDR > 8'h24 |=> O_RDATA == 32'h0)
        else $error("unmapped read not zero");
    a_irq_masked_low: assert property (ien_reg == 3'h0 |-> !O_IRQ)
        else $error("interrupt with all enables off");
    a_flag_set_irq: assert property (I_WR && I_ADDR == 8'h14
        && (I_WDATA[2:0] & ien_reg) != 3'h0 |=> O_IRQ)
        else $error("flag set did not raise interrupt");
    a_flag_clear_irq: assert property (I_WR && I_ADDR == 8'h18
        && I_WDATA[2:0] == 3'h7 && age_reg > 5'h10 |=> !O_IRQ)
        else $error("flag clear left interrupt high");
    a_start_with_event: assert property (O_TIMER_START == O_EVT_CMP0)
        else $error("timer start differs from event");
    a_event_after_tick: assert property ($changed(O_EVT_CMP0) |-> age_reg inside {[1:9]})
        else $error("event changed away from a tick");
    a_reset_quiet: assert property ($fell(I_RST) |-> !O_IRQ && !O_EVT_CMP0 && O_RDATA == 32'h0)
        else $error("outputs not quiet after reset");
endmodule
bind rtcc_top rtcc_top_assertions #(.CNT_W(CNT_W)) u_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_TICK(I_TICK), .O_IRQ(O_IRQ), .O_EVT_CMP0(O_EVT_CMP0), .O_TIMER_START(O_TIMER_START));

// >>> test/rtcc_top_tb.sv
`timescale 1ns/1ps
module rtcc_top_tb;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, tick = 1'b0, halt = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, seed = 32'hb0a33403;
    wire [31:0] rdata;
    wire irq, e0, e1, ts;
    int errors = 0, cmp_count = 0, pend = 0;
    int m [8] = '{default: 0};
    rtcc_top uut (.I_CORE_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
        .I_RD(rd), .O_RDATA(rdata), .I_TICK(tick), .I_DBG_HALT(halt), .O_IRQ(irq),
        .O_EVT_CMP0(e0), .O_EVT_CMP1(e1), .O_TIMER_START(ts));
    initial begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], ^(seed & 32'h80200003)};
        return seed;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic conclude();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        case (a[4:2])
            3'h5: m[4] |= d & 7;
            3'h6: m[4] &= ~d;
            default: m[a[4:2]] = d;
        endcase
        if (!m[0][0])
            m[1] = 0;
    endtask
    task automatic rd_chk(input logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, a == 8'h24 ? pend : (a < 8'h20 ? m[a[4:2]] : 0));
        chk(irq, |(m[4] & m[7]));
    endtask
    // One counter tick; events are sampled while they must still stand.
    task automatic pulse();
        @(posedge clk);
        tick <= 1'b1;
        repeat (10) @(posedge clk);
        tick <= 1'b0;
        repeat (10) @(posedge clk);
        #1;
        if (m[0][0] && (!halt || m[0][1])) begin
            chk(e0, m[1] == m[2]);
            chk(ts, m[1] == m[2]);
            chk(e1, m[1] == m[3]);
            m[4] |= (m[1] == m[2] ? 2 : 0) | (m[1] == m[3] ? 4 : 0);
            if (m[1] == (m[0][2] ? m[2] : 32'hffffff)) begin
                m[4] |= m[0][2] ? 0 : 1;
                m[1] = 0;
            end else
                m[1]++;
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i += 1)
            rd_chk(8'(i * 4));
        rd_chk(8'h30);
        repeat (4) begin
            wr_reg(8'h0c, lfsr() & 32'hffffff);
            rd_chk(8'h0c);
        end
        wr_reg(8'h0c, 32'h800000);
        wr_reg(8'h08, 32'h3);
        // Both match writes are still moving into the counter domain.
        pend = 6;
        rd_chk(8'h24);
        pend = 0;
        wr_reg(8'h00, 32'h1);
        repeat (4) pulse();
        rd_chk(8'h04);
        wr_reg(8'h1c, 32'h4);
        wr_reg(8'h14, 32'h5);
        rd_chk(8'h10);
        wr_reg(8'h18, 32'h3);
        rd_chk(8'h10);
        wr_reg(8'h1c, 32'h1);
        wr_reg(8'h04, 32'hfffffe);
        rd_chk(8'h04);
        repeat (2) pulse();
        rd_chk(8'h10);
        halt <= 1'b1;
        repeat (8) @(posedge clk);
        pulse();
        rd_chk(8'h04);
        wr_reg(8'h00, 32'h3);
        pulse();
        rd_chk(8'h04);
        halt <= 1'b0;
        wr_reg(8'h00, 32'h0);
        wr_reg(8'h00, 32'h5);
        repeat (5) pulse();
        rd_chk(8'h04);
        wr_reg(8'h18, 32'h7);
        rd_chk(8'h10);
        wr_reg(8'h00, 32'h0);
        rd_chk(8'h04);
        conclude();
    end
endmodule
